//--- rtl/eps_pkg.sv
package eps_pkg;
  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int unsigned CLK_HZ          = 50_000_000;
  localparam int unsigned FLASH_HALF_MS   = 500;
  localparam int unsigned FLASH_HALF_CYC  = (CLK_HZ / 1000) * FLASH_HALF_MS;
  localparam int unsigned FLASH_CNT_W     = 25;
  localparam int unsigned SCAN_DIV        = 4;
  localparam int unsigned SCAN_CNT_W      = 2;
  // ---------------------------------------------------------------
  // Structure and reset values
  // ---------------------------------------------------------------
  localparam int unsigned STAGES          = 4;
  localparam int unsigned FIFO_DEPTH      = 4;
  localparam int unsigned FIFO_WIDTH      = 4;
  localparam logic [3:0]  STAGES_RST      = 4'h0;
  localparam logic        BIT_RST         = 1'b0;

  typedef enum logic [1:0] {
    EPS_IDLE = 2'b00,
    EPS_ARM  = 2'b01,
    EPS_HOLD = 2'b11
  } eps_edge_t;
endpackage : eps_pkg

//--- rtl/eps_stage_if.sv
`timescale 1ns/1ps
`default_nettype none
interface eps_stage_if;
  logic [3:0] data;
  logic       valid;
  logic       ready;
  modport src (output data, output valid, input ready);
  modport snk (input data, input valid, output ready);
endinterface : eps_stage_if
`default_nettype wire

//--- rtl/eps_fifo.sv
`timescale 1ns/1ps
`default_nettype none
module eps_fifo #(
  parameter int unsigned WIDTH = 4,
  parameter int unsigned DEPTH = 4
) (
  // Clock and reset
  input  wire logic mclk,
  input  wire logic rst,
  input  wire logic ce,
  // Fill side
  eps_stage_if.snk  inSide,
  // Drain side
  output logic [WIDTH-1:0] outData,
  output logic             outValid,
  input  wire logic        outReady
);
  import eps_pkg::*;
  localparam int unsigned AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wrPtr_r, wrPtr_nxt, rdPtr_r, rdPtr_nxt;
  logic [AW:0]      count_r, count_nxt;
  logic             doWr, doRd;

  assign inSide.ready = (count_r != DEPTH[AW:0]);
  assign outValid     = (count_r != '0);
  assign outData      = mem[rdPtr_r];

  always_comb
  begin
    doWr      = inSide.valid && inSide.ready;
    doRd      = outValid && outReady;
    wrPtr_nxt = doWr ? wrPtr_r + 1'b1 : wrPtr_r;
    rdPtr_nxt = doRd ? rdPtr_r + 1'b1 : rdPtr_r;
    count_nxt = count_r + {{AW{1'b0}}, doWr} - {{AW{1'b0}}, doRd};
  end

  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      wrPtr_r <= '0;
      rdPtr_r <= '0;
      count_r <= '0;
    end
    else if (ce)
    begin
      wrPtr_r <= wrPtr_nxt;
      rdPtr_r <= rdPtr_nxt;
      count_r <= count_nxt;
      if (doWr)
        mem[wrPtr_r] <= inSide.data;
    end
  end
endmodule : eps_fifo
`default_nettype wire

//--- rtl/eps_flasher.sv
`timescale 1ns/1ps
`default_nettype none
module eps_flasher #(
  parameter int unsigned HALF = 25_000_000
) (
  // Clock and reset
  input  wire logic mclk,
  input  wire logic rst,
  input  wire logic ce,
  input  wire logic run,
  // Square wave
  output logic      flash
);
  import eps_pkg::*;
  logic [FLASH_CNT_W-1:0] cnt_r, cnt_nxt;
  logic                   flash_r, flash_nxt;

  assign flash = flash_r;

  always_comb
  begin
    cnt_nxt   = cnt_r + 1'b1;
    flash_nxt = flash_r;
    if (!run)
    begin
      cnt_nxt   = '0;
      flash_nxt = 1'b0;
    end
    else if (cnt_r >= HALF[FLASH_CNT_W-1:0] - 1'b1)
    begin
      cnt_nxt   = '0;
      flash_nxt = !flash_r;
    end
  end

  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      cnt_r   <= '0;
      flash_r <= BIT_RST;
    end
    else if (ce)
    begin
      cnt_r   <= cnt_nxt;
      flash_r <= flash_nxt;
    end
  end
endmodule : eps_flasher
`default_nettype wire

//--- rtl/eps_shift_top.sv
`timescale 1ns/1ps
`default_nettype none
module eps_shift_top #(
  parameter int unsigned FLASH_HALF = eps_pkg::FLASH_HALF_CYC
) (
  // Clock, reset, enable
  input  wire logic mclk,
  input  wire logic rst,
  input  wire logic ce,
  // Switch inputs
  input  wire logic shiftPulseIn,
  input  wire logic serialValueIn,
  input  wire logic clearIn,
  input  wire logic runLightMode,
  // Edge pulses of the shift input, or of the flasher in running-light mode
  output logic      risePulse,
  output logic      fallPulse,
  // Stage or lamp outputs
  output logic      lampOutOne,
  output logic      lampOutTwo,
  output logic      lampOutThree,
  output logic      lampOutFour
);
  import eps_pkg::*;

  // ---------------------------------------------------------------
  // Input synchronisers
  // ---------------------------------------------------------------
  logic [3:0] syA_r, syB_r;
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      syA_r <= '0;
      syB_r <= '0;
    end
    else if (ce)
    begin
      syA_r <= {runLightMode, clearIn, serialValueIn, shiftPulseIn};
      syB_r <= syA_r;
    end
  end
  logic pulseS, valueS, clearS, modeS;
  assign {modeS, clearS, valueS, pulseS} = syB_r;

  // ---------------------------------------------------------------
  // Scan tick: one program scan every SCAN_DIV clocks
  // ---------------------------------------------------------------
  logic [SCAN_CNT_W-1:0] scanCnt_r, scanCnt_nxt;
  logic                  scan;
  always_comb
  begin
    scanCnt_nxt = scanCnt_r + 1'b1;
    scan        = (scanCnt_r == SCAN_CNT_W'(SCAN_DIV - 1));
  end

  // ---------------------------------------------------------------
  // Flasher for running-light mode
  // ---------------------------------------------------------------
  logic flash;
  eps_flasher #(.HALF(FLASH_HALF)) uFlash (
    .mclk  (mclk),
    .rst   (rst),
    .ce    (ce),
    .run   (modeS),
    .flash (flash)
  );

  // ---------------------------------------------------------------
  // Scan logic: coils evaluated top to bottom, then published
  // ---------------------------------------------------------------
  logic       shiftSrc;
  logic       edgeMark_r, edgeMark_nxt;
  logic       strobe_r, strobe_nxt;
  logic       seed_r, seed_nxt;
  logic       rise_r, rise_nxt, fall_r, fall_nxt;
  logic [3:0] stage_r, stage_nxt;
  logic       serial;
  eps_edge_t  edgeSt_r, edgeSt_nxt;

  always_comb
  begin
    shiftSrc     = modeS ? flash : pulseS;
    serial       = modeS ? (!seed_r || stage_r[3]) : valueS;
    edgeMark_nxt = edgeMark_r;
    strobe_nxt   = strobe_r;
    seed_nxt     = seed_r;
    rise_nxt     = rise_r;
    fall_nxt     = fall_r;
    stage_nxt    = stage_r;
    edgeSt_nxt   = edgeSt_r;
    if (scan)
    begin
      // Contacts read old values; new values take effect next scan
      rise_nxt     = shiftSrc && !edgeMark_r;
      fall_nxt     = !shiftSrc && (edgeSt_r != EPS_IDLE);
      strobe_nxt   = shiftSrc && !edgeMark_r;
      edgeMark_nxt = shiftSrc;
      if (strobe_r)
        stage_nxt = {stage_r[2:0], serial};
      // Otherwise stages hold, unless clear is set
      if (modeS && stage_r[0])
        seed_nxt = 1'b1;
      if (!modeS)
        seed_nxt = 1'b0;
      if (clearS)
        stage_nxt = STAGES_RST;
      case (edgeSt_r)
        EPS_IDLE: edgeSt_nxt = shiftSrc ? EPS_ARM : EPS_IDLE;
        EPS_ARM:  edgeSt_nxt = shiftSrc ? EPS_HOLD : EPS_IDLE;
        EPS_HOLD: edgeSt_nxt = shiftSrc ? EPS_HOLD : EPS_IDLE;
        default:  edgeSt_nxt = EPS_IDLE;
      endcase
    end
  end

  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      scanCnt_r  <= '0;
      edgeMark_r <= BIT_RST;
      strobe_r   <= BIT_RST;
      seed_r     <= BIT_RST;
      rise_r     <= BIT_RST;
      fall_r     <= BIT_RST;
      stage_r    <= STAGES_RST;
      edgeSt_r   <= EPS_IDLE;
    end
    else if (ce)
    begin
      scanCnt_r  <= scanCnt_nxt;
      edgeMark_r <= edgeMark_nxt;
      strobe_r   <= strobe_nxt;
      seed_r     <= seed_nxt;
      rise_r     <= rise_nxt;
      fall_r     <= fall_nxt;
      stage_r    <= stage_nxt;
      edgeSt_r   <= edgeSt_nxt;
    end
  end

  // ---------------------------------------------------------------
  // Output path through the FIFO, always drained
  // ---------------------------------------------------------------
  eps_stage_if stageIf ();
  logic [3:0] fifoData;
  logic       fifoValid;
  logic [3:0] lamps_r;
  logic       risePulse_r, fallPulse_r;

  assign stageIf.data  = stage_r;
  assign stageIf.valid = scan;

  eps_fifo #(.WIDTH(FIFO_WIDTH), .DEPTH(FIFO_DEPTH)) uFifo (
    .mclk     (mclk),
    .rst      (rst),
    .ce       (ce),
    .inSide   (stageIf),
    .outData  (fifoData),
    .outValid (fifoValid),
    .outReady (1'b1)
  );

  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      lamps_r     <= STAGES_RST;
      risePulse_r <= BIT_RST;
      fallPulse_r <= BIT_RST;
    end
    else if (ce)
    begin
      if (fifoValid)
        lamps_r <= fifoData;
      risePulse_r <= rise_r && scan;
      fallPulse_r <= fall_r && scan;
    end
  end

  assign risePulse    = risePulse_r;
  assign fallPulse    = fallPulse_r;
  assign lampOutOne   = lamps_r[0];
  assign lampOutTwo   = lamps_r[1];
  assign lampOutThree = lamps_r[2];
  assign lampOutFour  = lamps_r[3];
endmodule : eps_shift_top
`default_nettype wire

//--- tb/eps_shift_props.sv
`timescale 1ns/1ps
`default_nettype none
module eps_shift_props #(
  parameter int unsigned FLASH_HALF = 8
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  input wire logic ce,
  // Switch inputs
  input wire logic shiftPulseIn,
  input wire logic serialValueIn,
  input wire logic clearIn,
  input wire logic runLightMode,
  // Pulses and lamps
  input wire logic risePulse,
  input wire logic fallPulse,
  input wire logic lampOutOne,
  input wire logic lampOutTwo,
  input wire logic lampOutThree,
  input wire logic lampOutFour
);
  logic [3:0] lamps;
  logic [4:0] quietCnt_r;
  logic [4:0] clrCnt_r;
  logic [6:0] runCnt_r;
  assign lamps = {lampOutOne, lampOutTwo, lampOutThree, lampOutFour};
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  // Cycles since the last cause of a lamp change, clear held, ring running
  always_ff @(posedge mclk)
  begin
    quietCnt_r <= (rst || risePulse || clearIn) ? 5'h00 : quietCnt_r + {4'h0, quietCnt_r != 5'h10};
    clrCnt_r <= (rst || !clearIn) ? 5'h00 : clrCnt_r + {4'h0, clrCnt_r != 5'h10};
    runCnt_r <= (rst || !runLightMode || clearIn) ? 7'h00 : runCnt_r + {6'h00, runCnt_r != 7'h40};
  end
  a_rise_single: assert property (risePulse |=> !risePulse [*7])
    else $error("rise pulse too long or repeated");
  a_fall_single: assert property (fallPulse |=> !fallPulse [*7])
    else $error("fall pulse too long or repeated");
  a_rise_follow: assert property (ce && !runLightMode && $rose(shiftPulseIn) |-> ##[1:12] risePulse)
    else $error("no rise pulse after shift input rose");
  a_fall_follow: assert property (ce && !runLightMode && $fell(shiftPulseIn) |-> ##[1:12] fallPulse)
    else $error("no fall pulse after shift input fell");
  a_reset_zero: assert property ($fell(rst) |-> lamps == 4'h0 && !risePulse && !fallPulse)
    else $error("outputs not cleared by reset");
  a_clear_zero: assert property (clrCnt_r == 5'h10 |-> lamps == 4'h0)
    else $error("lamps not cleared while clear held");
  a_lamps_hold: assert property (quietCnt_r == 5'h10 |-> $stable(lamps))
    else $error("lamps changed without a strobe");
  a_ring_onehot: assert property (runCnt_r == 7'h40 |-> $onehot(lamps))
    else $error("running light not exactly one lamp");
endmodule : eps_shift_props
`default_nettype wire

//--- tb/eps_switch_model.sv
`timescale 1ns/1ps
`default_nettype none
module eps_switch_model (
  // Clock
  input wire logic mclk,
  // Requested contact states
  input wire logic wantShift,
  input wire logic wantGood,
  input wire logic wantClear,
  // Contacts toward the block
  output logic     shiftPulseIn = 1'b0,
  output logic     serialValueIn = 1'b0,
  output logic     clearIn = 1'b0
);
  // A good part closes the value contact, a bad part leaves it open
  always @(posedge mclk)
  begin
    shiftPulseIn <= wantShift;
    serialValueIn <= wantGood;
    clearIn <= wantClear;
  end
endmodule : eps_switch_model
`default_nettype wire

//--- tb/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic ce = 1'b1;
  logic runLightMode = 1'b0;
  logic wantShift = 1'b0;
  logic wantGood = 1'b0;
  logic wantClear = 1'b0;
  logic shiftPulseIn, serialValueIn, clearIn;
  logic risePulse, fallPulse, lampOutOne, lampOutTwo, lampOutThree, lampOutFour;
  logic [3:0] lamps;
  int failures = 0;
  int samples_checked = 0;
  assign lamps = {lampOutOne, lampOutTwo, lampOutThree, lampOutFour};
  initial
  begin
    forever #10 mclk = ~mclk;
  end
  eps_switch_model i_sw (.mclk(mclk), .wantShift(wantShift), .wantGood(wantGood), .wantClear(wantClear),
    .shiftPulseIn(shiftPulseIn), .serialValueIn(serialValueIn), .clearIn(clearIn));
  eps_shift_top #(.FLASH_HALF(8)) i_dut (.mclk(mclk), .rst(rst), .ce(ce), .shiftPulseIn(shiftPulseIn),
    .serialValueIn(serialValueIn), .clearIn(clearIn), .runLightMode(runLightMode), .risePulse(risePulse),
    .fallPulse(fallPulse), .lampOutOne(lampOutOne), .lampOutTwo(lampOutTwo), .lampOutThree(lampOutThree),
    .lampOutFour(lampOutFour));
  task automatic chk(input logic [3:0] got, input logic [3:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      failures++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic end_sim;
    if (failures == 0 && samples_checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : end_sim
  // Press the shift switch with a value, counting edge pulses
  task automatic shift_one(input logic v, output logic [3:0] r, output logic [3:0] f);
    r = 4'h0;
    f = 4'h0;
    @(posedge mclk);
    wantGood <= v;
    wantShift <= 1'b1;
    repeat (24)
    begin
      @(negedge mclk);
      r = r + {3'h0, risePulse};
    end
    @(posedge mclk);
    wantShift <= 1'b0;
    repeat (24)
    begin
      @(negedge mclk);
      f = f + {3'h0, fallPulse};
    end
  endtask : shift_one
  task automatic clear_all;
    @(posedge mclk);
    wantClear <= 1'b1;
    repeat (16) @(posedge mclk);
    wantClear <= 1'b0;
    repeat (20) @(negedge mclk);
  endtask : clear_all
  task automatic t_table;
    logic [3:0] r;
    logic [3:0] f;
    logic [3:0] exp;
    logic [4:0] vals;
    vals = 5'h09;
    exp = 4'h0;
    for (int i = 0; i < 5; i++)
    begin
      shift_one(vals[i], r, f);
      exp = {vals[i], exp[3:1]};
      chk(r, 4'h1);
      chk(f, 4'h1);
      chk(lamps, exp);
    end
    clear_all();
    chk(lamps, 4'h0);
  endtask : t_table
  task automatic t_clear_wins;
    logic [3:0] r;
    logic [3:0] f;
    shift_one(1'b1, r, f);
    chk(lamps, 4'h8);
    @(posedge mclk);
    wantClear <= 1'b1;
    shift_one(1'b1, r, f);
    chk(r, 4'h1);
    chk(lamps, 4'h0);
    clear_all();
  endtask : t_clear_wins
  task automatic t_run_light;
    logic [3:0] exp;
    logic [3:0] prev;
    int n;
    exp = 4'h8;
    prev = 4'h0;
    @(posedge mclk);
    runLightMode <= 1'b1;
    for (int k = 0; k < 6; k++)
    begin
      n = 0;
      while (lamps === prev && n < 200)
      begin
        @(negedge mclk);
        n++;
      end
      if (n == 200)
      begin
        failures++;
        end_sim();
      end
      chk(lamps, exp);
      if (k > 0)
        chk(4'(n / 4), 4'h4);
      prev = exp;
      exp = {exp[0], exp[3:1]};
    end
    @(posedge mclk);
    runLightMode <= 1'b0;
    clear_all();
  endtask : t_run_light
  // Reset in mid-run must clear the stored stages, not only the lamps
  task automatic t_reset;
    logic [3:0] r;
    logic [3:0] f;
    shift_one(1'b1, r, f);
    chk(lamps, 4'h8);
    @(posedge mclk);
    rst <= 1'b1;
    repeat (6) @(posedge mclk);
    rst <= 1'b0;
    repeat (2)
    begin
      @(negedge mclk);
      chk({risePulse, fallPulse, 2'h0} | lamps, 4'h0);
    end
    shift_one(1'b1, r, f);
    chk(lamps, 4'h8);
  endtask : t_reset
  // Clock enable low: a full switch press leaves no trace
  task automatic t_freeze;
    logic [3:0] r;
    logic [3:0] f;
    @(posedge mclk);
    ce <= 1'b0;
    shift_one(1'b1, r, f);
    chk(r | f, 4'h0);
    chk(lamps, 4'h8);
    @(posedge mclk);
    ce <= 1'b1;
    repeat (12) @(negedge mclk);
    chk(lamps, 4'h8);
  endtask : t_freeze
  initial
  begin
    repeat (6) @(posedge mclk);
    rst <= 1'b0;
    @(negedge mclk);
    chk({risePulse, fallPulse, 2'h0} | lamps, 4'h0);
    t_table();
    t_clear_wins();
    t_run_light();
    t_reset();
    t_freeze();
    end_sim();
  end
endmodule : tb
bind eps_shift_top eps_shift_props #(.FLASH_HALF(FLASH_HALF)) i_props (.mclk(mclk), .rst(rst), .ce(ce),
  .shiftPulseIn(shiftPulseIn), .serialValueIn(serialValueIn), .clearIn(clearIn), .runLightMode(runLightMode),
  .risePulse(risePulse), .fallPulse(fallPulse), .lampOutOne(lampOutOne), .lampOutTwo(lampOutTwo),
  .lampOutThree(lampOutThree), .lampOutFour(lampOutFour));
`default_nettype wire
